//--- hw/pmcc_pkg.sv
/*
 * constants shared by the monitor count-control logic: register numbers,
 * field positions of the mode control word, reset values and widths.
 * assumes the processor core presents its special-register moves as one
 * number, a read or write strobe and a 32-bit data word.
 */
// Behaviour
// R1 - 32-bit control register at special register 952
// R2 - access allowed only in supervisor state
// R3 - reads have no side effects at all
// R4 - control register clears to zero at power-up
// R5 - freeze_all stops every counter change; here it stops only the steps, and software loads still change a counter
// R6 - freeze_in_supervisor stops counting in supervisor state
// R7 - freeze_in_user stops counting in user state
// R8 - freeze_when_marked stops counting while marked
// R9 - freeze_when_unmarked stops counting while unmarked
// R10 - monitor_irq_enable gates every monitor interrupt
// R11 - hardware clears monitor_irq_enable when signalling; here a mode write in the same cycle wins over the clear
// R12 - software re-enables interrupt after servicing it
// R13 - halt bit clear: interrupt leaves counting alone
// R14 - halt bit set: interrupt stops first counter
// R15 - halt, no trigger: counters two-four stop too
// R16 - enabled time-base transition also halts counting
// R17 - software returns transition interrupt setting to zero
// R18 - counter negative on top bit, gated interrupt
// R19 - trigger mode holds counters two-four until release
// R20 - chosen time-base bit rising signals an interrupt
// R21 - counters increment only when no freeze applies
package pmcc_pkg;

  // ****************************************************************
  // register numbers
  // ****************************************************************
  localparam logic [9:0] SPR_NUM_W       = 10;
  localparam logic [9:0] MODE_CTRL_SPR   = 10'h3b8; // special register 952
  localparam logic [9:0] COUNTER_SPR_0   = 10'h3e0;
  localparam logic [9:0] COUNTER_SPR_1   = 10'h3e1;
  localparam logic [9:0] COUNTER_SPR_2   = 10'h3e2;
  localparam logic [9:0] COUNTER_SPR_3   = 10'h3e3;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int          DATA_W         = 32;
  localparam int          NUM_COUNTERS   = 4;
  localparam logic [31:0] MODE_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] COUNTER_RST    = 32'h0000_0000;

  // ****************************************************************
  // field positions, bit 0 of the word is its most significant bit
  // ****************************************************************
  localparam int FREEZE_ALL_POS          = 31; // word bit 0
  localparam int FREEZE_SUPV_POS         = 30; // word bit 1
  localparam int FREEZE_USER_POS         = 29; // word bit 2
  localparam int FREEZE_MARKED_POS       = 28; // word bit 3
  localparam int FREEZE_UNMARKED_POS     = 27; // word bit 4
  localparam int IRQ_ENABLE_POS          = 26; // word bit 5
  localparam int HALT_ON_IRQ_POS         = 25; // word bit 6
  localparam int TB_SELECT_HI_POS        = 24; // word bits 7-8
  localparam int TB_SELECT_LO_POS        = 23;
  localparam int TB_IRQ_POS              = 22; // word bit 9
  localparam int FIRST_NEG_IRQ_POS       = 15; // word bit 16
  localparam int OTHER_NEG_IRQ_POS       = 14; // word bit 17
  localparam int TRIGGER_MODE_POS        = 13; // word bit 18
  localparam int COUNTER_SIGN_POS        = 31; // counter bit 0

endpackage

//--- hw/pmcc_counter.sv
/*
 * one event counter: loadable by software, stepped by one qualified event.
 * assumes load and step come from logic on the same clock.
 */
`timescale 1ns/100ps

module pmcc_counter
#(
  parameter int W = 32
)
(
  // clock and reset
  input  wire logic          REF_CLK,
  input  wire logic          SYS_RST,
  // control
  input  wire logic          LOAD,
  input  wire logic [W-1:0]  LOAD_VALUE,
  input  wire logic          STEP,
  // state
  output logic      [W-1:0]  VALUE
);
  import pmcc_pkg::*;

  logic [W-1:0] value_reg;

  // a software load wins over a step in the same cycle
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      value_reg <= W'(COUNTER_RST);
    else if (LOAD)
      value_reg <= LOAD_VALUE;
    else if (STEP)
      value_reg <= value_reg + W'(1); // wraps past all ones
  end

  assign VALUE = value_reg;

endmodule

//--- hw/pmcc_top.sv
/*
 * performance monitor count control: the mode control register, the
 * freeze qualification of four event counters, the monitor interrupt and
 * the halt and trigger behaviour around it.
 * assumes events, problem state, mark bit and time-base taps all come from
 * core logic on REF_CLK, so none of them is synchronised here.
 */
`timescale 1ns/100ps

module pmcc_top
(
  // clock and reset
  input  wire logic                            REF_CLK,
  input  wire logic                            SYS_RST,
  // special register moves from the core
  input  wire logic [9:0]                      SPR_NUM,
  input  wire logic                            SPR_RD,
  input  wire logic                            SPR_WR,
  input  wire logic [pmcc_pkg::DATA_W-1:0]     SPR_WDATA,
  output logic      [pmcc_pkg::DATA_W-1:0]     SPR_RDATA,
  output logic                                 SPR_ACK,
  output logic                                 SPR_PRIV_FAULT,
  // processor state
  input  wire logic                            PROBLEM_STATE,
  input  wire logic                            PERF_MARK,
  // event sources, one per counter, and time-base taps 63,55,51,47
  input  wire logic [pmcc_pkg::NUM_COUNTERS-1:0] EVENT,
  input  wire logic [3:0]                      TB_TAPS,
  // results
  output logic                                 MONITOR_IRQ,
  output logic [pmcc_pkg::NUM_COUNTERS-1:0]    COUNTER_NEGATIVE
);
  import pmcc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [DATA_W-1:0]       mode_reg;
  logic [DATA_W-1:0]       rdata_reg;
  logic                    ack_reg;
  logic                    fault_reg;
  logic                    irq_reg;
  logic                    halt_first_reg;
  logic                    halt_other_reg;
  logic                    released_reg;
  logic [3:0]              taps_reg;
  logic [NUM_COUNTERS-1:0] neg_reg;

  logic [DATA_W-1:0]       count [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] load;
  logic [NUM_COUNTERS-1:0] step;

  logic                    access;
  logic                    supervisor;
  logic                    wr_ok;
  logic                    mode_wr;
  logic                    freeze_common;
  logic                    tb_rise;
  logic                    first_neg;
  logic                    other_neg;
  logic                    irq_cause;
  logic                    irq_fire;
  logic                    trig_hold;
  logic [DATA_W-1:0]       mode_next;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // tell whether a register number is the register of one given counter index
  function automatic logic counter_hit(input logic [9:0] num,
                                       input int         idx);
    logic [9:0] base;
    base = COUNTER_SPR_0 + 10'(idx);
    counter_hit = (num == base);
  endfunction

  function automatic logic mapped(input logic [9:0] num);
    logic hit;
    hit = (num == MODE_CTRL_SPR);
    for (int i = 0; i < NUM_COUNTERS; i++)
    begin
      hit = hit | counter_hit(num, i);
    end
    mapped = hit;
  endfunction

  // ****************************************************************
  // register access
  // ****************************************************************
  assign access     = (SPR_RD | SPR_WR) & mapped(SPR_NUM);
  assign supervisor = ~PROBLEM_STATE;
  assign wr_ok      = SPR_WR & supervisor;                  // see R2
  assign mode_wr    = wr_ok & (SPR_NUM == MODE_CTRL_SPR);   // see R1

  // counter loads from software, only in supervisor state
  always_comb
  begin
    for (int i = 0; i < NUM_COUNTERS; i++)
    begin
      load[i] = wr_ok & counter_hit(SPR_NUM, i);
    end
  end

  // read data is captured only; reading touches no state  // see R3
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      rdata_reg <= '0;
    else if (SPR_RD & supervisor & (SPR_NUM == MODE_CTRL_SPR))
      rdata_reg <= mode_reg;                             // see R1
    else if (SPR_RD & supervisor)
    begin
      rdata_reg <= '0;
      for (int i = 0; i < NUM_COUNTERS; i++)
      begin
        if (counter_hit(SPR_NUM, i))
          rdata_reg <= count[i];
      end
    end
    else
      rdata_reg <= '0;                                   // see R2
  end

  // every mapped access answers one cycle later; user state faults it
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      ack_reg   <= 1'b0;
      fault_reg <= 1'b0;
    end
    else
    begin
      ack_reg   <= access;
      fault_reg <= access & ~supervisor;                 // see R2
    end
  end

  // ****************************************************************
  // mode control register
  // ****************************************************************
  // a software write wins over the hardware clear of the enable bit in
  // the same cycle, so a re-enable written during signalling sticks
  always_comb
  begin
    mode_next = mode_reg;
    if (irq_fire)
      mode_next[IRQ_ENABLE_POS] = 1'b0;                  // see R11
    if (mode_wr)
      mode_next = SPR_WDATA;                             // see R12
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      mode_reg <= MODE_CTRL_RST;                         // see R4
    else
      mode_reg <= mode_next;
  end

  // ****************************************************************
  // freeze qualification
  // ****************************************************************
  assign freeze_common =
      mode_reg[FREEZE_ALL_POS]                                 // see R5
    | (mode_reg[FREEZE_SUPV_POS]     & ~PROBLEM_STATE)         // see R6
    | (mode_reg[FREEZE_USER_POS]     &  PROBLEM_STATE)         // see R7
    | (mode_reg[FREEZE_MARKED_POS]   &  PERF_MARK)             // see R8
    | (mode_reg[FREEZE_UNMARKED_POS] & ~PERF_MARK);            // see R9

  // released by the latch, or at once while the first counter is negative
  assign trig_hold = mode_reg[TRIGGER_MODE_POS] & ~released_reg & ~first_neg;

  // one step per qualified event, all inhibits ORed together  // see R21
  always_comb
  begin
    step[0] = EVENT[0] & ~freeze_common & ~halt_first_reg;  // see R14
    for (int i = 1; i < NUM_COUNTERS; i++)
    begin
      step[i] = EVENT[i] & ~freeze_common & ~halt_other_reg
              & ~trig_hold;                                 // see R15
    end
  end

  // ****************************************************************
  // counters
  // ****************************************************************
  for (genvar g = 0; g < NUM_COUNTERS; g++)
  begin : g_cnt
    pmcc_counter
    #(
      .W          (DATA_W)
    )
    u_cnt
    (
      .REF_CLK    (REF_CLK),
      .SYS_RST    (SYS_RST),
      .LOAD       (load[g]),
      .LOAD_VALUE (SPR_WDATA),
      .STEP       (step[g]),
      .VALUE      (count[g])
    );
  end

  // ****************************************************************
  // interrupt causes
  // ****************************************************************
  // negative means the top bit is set  // see R18
  assign first_neg = count[0][COUNTER_SIGN_POS];
  always_comb
  begin
    other_neg = 1'b0;
    for (int i = 1; i < NUM_COUNTERS; i++)
    begin
      other_neg = other_neg | count[i][COUNTER_SIGN_POS];
    end
  end

  // off-to-on edge of the selected time-base tap  // see R20
  assign tb_rise = TB_TAPS[mode_reg[TB_SELECT_HI_POS:TB_SELECT_LO_POS]]
                 & ~taps_reg[mode_reg[TB_SELECT_HI_POS:TB_SELECT_LO_POS]];

  assign irq_cause =
      (first_neg & mode_reg[FIRST_NEG_IRQ_POS])                // see R18
    | (other_neg & mode_reg[OTHER_NEG_IRQ_POS])
    | (tb_rise   & mode_reg[TB_IRQ_POS]);                      // see R20

  // nothing is signalled while the enable bit is clear  // see R10
  assign irq_fire = irq_cause & mode_reg[IRQ_ENABLE_POS];

  // tap history for the edge detector
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      taps_reg <= 4'h0;
    else
      taps_reg <= TB_TAPS;
  end

  // the interrupt output is one pulse per signalling
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_fire;
  end

  // ****************************************************************
  // halt and trigger state
  // ****************************************************************
  // the halt latches stay until software rewrites the mode word; the set
  // wins over that write so a coincident signalling is not lost. a time-
  // base signalling is a signalling too, so it halts the same way, which
  // is why software should drop the transition setting after it fires
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      halt_first_reg <= 1'b0;
      halt_other_reg <= 1'b0;
    end
    else
    begin
      if (irq_fire & mode_reg[HALT_ON_IRQ_POS])              // see R16
        halt_first_reg <= 1'b1;                              // see R14
      else if (mode_wr)
        halt_first_reg <= 1'b0;
      // with trigger mode set the later counters follow the trigger
      if (irq_fire & mode_reg[HALT_ON_IRQ_POS]
          & ~mode_reg[TRIGGER_MODE_POS])                      // see R15
        halt_other_reg <= 1'b1;
      else if (mode_wr)
        halt_other_reg <= 1'b0;                              // see R13
    end
  end

  // trigger release on first counter negative or any signalling
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      released_reg <= 1'b0;
    else if (first_neg | irq_fire)                           // see R19
      released_reg <= 1'b1;
    else if (mode_wr)
      released_reg <= 1'b0;
  end

  // registered copy of each counter's sign for the outside
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      neg_reg <= '0;
    else
    begin
      for (int i = 0; i < NUM_COUNTERS; i++)
      begin
        neg_reg[i] <= count[i][COUNTER_SIGN_POS];
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign SPR_RDATA        = rdata_reg;
  assign SPR_ACK          = ack_reg;
  assign SPR_PRIV_FAULT   = fault_reg;
  assign MONITOR_IRQ      = irq_reg;
  assign COUNTER_NEGATIVE = neg_reg;

endmodule

//--- bench/pmcc_top_monitor.sv
/* checker for pmcc_top: register moves, freeze and interrupt gating.
   assumes one clock REF_CLK and synchronous active-high SYS_RST. */
`timescale 1ns/100ps

module pmcc_top_monitor
  import pmcc_pkg::*;
(
  // clock and reset
  input wire logic                    REF_CLK,
  input wire logic                    SYS_RST,
  // register moves
  input wire logic [9:0]              SPR_NUM,
  input wire logic                    SPR_RD,
  input wire logic                    SPR_WR,
  input wire logic [DATA_W-1:0]       SPR_WDATA,
  input wire logic [DATA_W-1:0]       SPR_RDATA,
  input wire logic                    SPR_ACK,
  input wire logic                    SPR_PRIV_FAULT,
  // state, events and results
  input wire logic                    PROBLEM_STATE,
  input wire logic                    PERF_MARK,
  input wire logic [NUM_COUNTERS-1:0] EVENT,
  input wire logic [3:0]              TB_TAPS,
  input wire logic                    MONITOR_IRQ,
  input wire logic [NUM_COUNTERS-1:0] COUNTER_NEGATIVE
);
  logic       acc, mapped, wr_mode, frz, en_q;
  logic [4:0] fz_q;
  logic [1:0] qcnt;
  // ****************************************************************
  // shadow of the freeze and enable bits, seen from the writes and the interrupt output
  // ****************************************************************
  assign acc = SPR_RD | SPR_WR;
  assign mapped = SPR_NUM == MODE_CTRL_SPR || SPR_NUM[9:2] == 8'hf8;
  assign wr_mode = SPR_WR & ~PROBLEM_STATE & (SPR_NUM == MODE_CTRL_SPR);
  assign frz = fz_q[4] | (fz_q[3] & ~PROBLEM_STATE) |
               (fz_q[2] & PROBLEM_STATE) | (fz_q[1] & PERF_MARK) |
               (fz_q[0] & ~PERF_MARK);
  // the enable shadow clears a cycle late, so it over-reports, but it drops a re-enable written the cycle before MONITOR_IRQ rises
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      fz_q <= 5'h00;
      en_q <= 1'b0;
      qcnt <= 2'h0;
    end
    else
    begin
      if (wr_mode)
        fz_q <= SPR_WDATA[31:27];
      en_q <= wr_mode ? SPR_WDATA[IRQ_ENABLE_POS] : en_q & ~MONITOR_IRQ;
      // counter loads restart the quiet count
      if (!frz || (SPR_WR && mapped))
        qcnt <= 2'h0;
      else if (qcnt != 2'h3)
        qcnt <= qcnt + 2'h1;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  property p_ack; acc && mapped |=> SPR_ACK; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_nomap; acc && !mapped |=> !SPR_ACK; endproperty
  a_nomap: assert property (p_nomap) else $error("stray ack");
  property p_fault;
    acc && mapped && PROBLEM_STATE |=> SPR_PRIV_FAULT && SPR_RDATA == '0;
  endproperty
  a_fault: assert property (p_fault) else $error("no fault");
  property p_nofault; acc && !PROBLEM_STATE |=> !SPR_PRIV_FAULT; endproperty
  a_nofault: assert property (p_nofault) else $error("bad fault");
  property p_idle; !SPR_ACK |-> SPR_RDATA == '0; endproperty
  a_idle: assert property (p_idle) else $error("rdata leak");
  property p_freeze; qcnt == 2'h3 |-> $stable(COUNTER_NEGATIVE); endproperty
  a_freeze:
    assert property (p_freeze) else $error("frozen moved");
  property p_gate; MONITOR_IRQ |-> $past(en_q); endproperty
  a_gate: assert property (p_gate) else $error("irq not enabled");
  property p_once; MONITOR_IRQ && !$past(wr_mode) |=> !MONITOR_IRQ; endproperty
  a_once: assert property (p_once) else $error("irq refired");
endmodule

bind pmcc_top pmcc_top_monitor u_pmcc_top_monitor (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SPR_NUM(SPR_NUM),
  .SPR_RD(SPR_RD), .SPR_WR(SPR_WR), .SPR_WDATA(SPR_WDATA),
  .SPR_RDATA(SPR_RDATA), .SPR_ACK(SPR_ACK),
  .SPR_PRIV_FAULT(SPR_PRIV_FAULT), .PROBLEM_STATE(PROBLEM_STATE),
  .PERF_MARK(PERF_MARK), .EVENT(EVENT), .TB_TAPS(TB_TAPS),
  .MONITOR_IRQ(MONITOR_IRQ), .COUNTER_NEGATIVE(COUNTER_NEGATIVE));

//--- bench/pmcc_top_bench.sv
/* self-checking bench for pmcc_top: moves, freeze table, interrupt.
   assumes pmcc_pkg; inputs change on the falling edge. */
`timescale 1ns/100ps

module pmcc_top_bench;
  import pmcc_pkg::*;
  logic        ref_clk = 0, sys_rst = 1, spr_rd = 0, spr_wr = 0;
  logic        prob = 0, mark = 0, irq, ack, fault;
  logic [9:0]  num = '0;
  logic [31:0] wdata = '0, rdata, d, m;
  logic [3:0]  ev = '0, taps = '0, neg;
  logic [33:0] exp_q[$]; // {data checked, fault, data}
  logic [33:0] e;
  int err_total = 0, n_tests = 0, cyc = 0, irqs = 0, n, irq0, sel;
  int pos_a[10] = '{31, 30, 30, 29, 29, 28, 28, 27, 27, 0};
  int ps_a[10] = '{0, 0, 1, 1, 0, 0, 0, 0, 0, 0};
  int pm_a[10] = '{0, 0, 0, 0, 0, 1, 0, 0, 1, 0};
  int fz_a[10] = '{1, 1, 0, 1, 0, 1, 0, 1, 0, 0};
  logic [31:0] md_a[3] = '{32'h0600_8000, 32'h0400_8000, 32'h0000_8000};
  int irq_a[4] = '{1, 1, 0, 1};

  pmcc_top u_pmcc_top (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .SPR_NUM(num), .SPR_RD(spr_rd),
    .SPR_WR(spr_wr), .SPR_WDATA(wdata), .SPR_RDATA(rdata), .SPR_ACK(ack),
    .SPR_PRIV_FAULT(fault), .PROBLEM_STATE(prob), .PERF_MARK(mark),
    .EVENT(ev), .TB_TAPS(taps), .MONITOR_IRQ(irq),
    .COUNTER_NEGATIVE(neg));

  always #5 ref_clk = ~ref_clk;

  // ****************************************************************
  // compare, report and move tasks
  // ****************************************************************
  task automatic check(string what, logic [32:0] x, logic [32:0] s);
    n_tests++;
    if (s !== x)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, x, s);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one move, held across the taking edge; a note only when answered
  task automatic mv(logic w, logic [9:0] a, logic [31:0] v, logic [33:0] x,
                    logic ans);
    if (ans)
      exp_q.push_back(x);
    @(negedge ref_clk);
    spr_rd = ~w;
    spr_wr = w;
    num = a;
    wdata = v;
    @(negedge ref_clk);
    spr_rd = 0;
    spr_wr = 0;
  endtask

  task automatic wr(logic [9:0] a, logic [31:0] v, logic f);
    mv(1, a, v, {1'b0, f, 32'h0}, 1);
  endtask

  task automatic rd(logic [9:0] a, logic [31:0] v, logic f);
    mv(0, a, 32'h0, {1'b1, f, v}, 1);
  endtask

  // watcher: bounded run, interrupt count, answers against notes; looks
  // at the falling edge so registered outputs have settled
  always @(negedge ref_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      complete_run();
    end
    if (irq === 1'b1)
      irqs++;
    if (ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("ack", 33'h0, 33'h1);
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
      check("fault", 33'(e[32]), 33'(fault));
      if (e[33])
        check("rdata", 33'(e[31:0]), 33'(rdata));
    end
  end

  initial
  begin
    void'($urandom(29415));
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 0;
    rd(MODE_CTRL_SPR, 0, 0);
    for (int i = 0; i < 4; i++)
      rd(COUNTER_SPR_0 | 10'(i), 0, 0);
    d = $urandom();
    wr(MODE_CTRL_SPR, d, 0);
    rd(MODE_CTRL_SPR, d, 0);
    rd(MODE_CTRL_SPR, d, 0);
    mv(0, 10'h3b9, 0, 0, 0);
    prob = 1;
    wr(MODE_CTRL_SPR, ~d, 1);
    rd(MODE_CTRL_SPR, 0, 1);
    prob = 0;
    rd(MODE_CTRL_SPR, d, 0);
    // freeze table: one inhibit bit, or bit 0 with none, against problem state and mark
    for (int i = 0; i < 10; i++)
    begin
      n = 5 + $urandom_range(7);
      wr(MODE_CTRL_SPR, 32'h1 << pos_a[i], 0);
      // start near the sign bit so any leak also moves the negative flag
      wr(COUNTER_SPR_3, 32'h7fff_fffc, 0);
      prob = ps_a[i];
      mark = pm_a[i];
      ev = 4'($urandom()) | 4'h8;
      repeat (n) @(negedge ref_clk);
      ev = 0;
      prob = 0;
      d = fz_a[i] ? 32'h7fff_fffc : 32'h7fff_fffc + 32'(n);
      rd(COUNTER_SPR_3, d, 0);
      check("neg3", 33'(fz_a[i] == 0), 33'(neg[3]));
    end
    // interrupt from counter negative or time-base tap, halt or not
    for (int i = 0; i < 4; i++)
    begin
      sel = $urandom_range(3);
      m = (i == 3) ? 32'h0640_0000 | (32'(sel) << 23) : md_a[i];
      irq0 = irqs;
      wr(MODE_CTRL_SPR, 0, 0);
      wr(COUNTER_SPR_0, 32'h7fff_fffe, 0);
      wr(COUNTER_SPR_1, 5, 0);
      wr(MODE_CTRL_SPR, m, 0);
      ev = 4'h1;
      repeat (2) @(negedge ref_clk);
      ev = 0;
      taps[sel] = (i == 3);
      repeat (4) @(negedge ref_clk);
      taps = 0;
      ev = 4'h3;
      repeat (5) @(negedge ref_clk);
      ev = 0;
      n = irqs - irq0;
      check("irqs", 33'(irq_a[i]), 33'(n));
      rd(MODE_CTRL_SPR, m & ~32'h0400_0000, 0);
      d = m[25] ? 32'h8000_0000 : 32'h8000_0005;
      rd(COUNTER_SPR_0, d, 0);
      rd(COUNTER_SPR_1, m[25] ? 5 : 10, 0);
    end
    // trigger mode: second counter waits until the first turns negative
    wr(MODE_CTRL_SPR, 0, 0);
    wr(COUNTER_SPR_0, 32'h7fff_fffd, 0);
    wr(COUNTER_SPR_1, 5, 0);
    wr(MODE_CTRL_SPR, 32'h0000_2000, 0);
    ev = 4'h3;
    repeat (5) @(negedge ref_clk);
    ev = 0;
    rd(COUNTER_SPR_0, 32'h8000_0002, 0);
    rd(COUNTER_SPR_1, 7, 0);
    check("neg", 33'h9, 33'(neg));
    // re-enable with the later counters' negative control: one more irq
    irq0 = irqs;
    wr(MODE_CTRL_SPR, 32'h0400_4000, 0);
    repeat (3) @(negedge ref_clk);
    n = irqs - irq0;
    check("irqs", 33'h1, 33'(n));
    rd(MODE_CTRL_SPR, 32'h0000_4000, 0);
    wr(MODE_CTRL_SPR, 0, 0);
    repeat (3) @(negedge ref_clk);
    complete_run();
  end
endmodule
